// [sbis_core.sv]
// bus reinitialize, arbitration reset and block-next-request stall handling
// What this block does
// [RL1] one bus clock launches and captures everything
// [RL2] all timing on rising edge of clock
// [RL3] drive reinitialize on fatal error when enabled
// [RL4] observation enable strapped at reset
// [RL5] observed reinitialize resets both arbiters
// [RL6] reinitialize keeps queue and tracking state
// [RL7] re-arbitrate then finish pending queue entries
// [RL8] priority agent handles disabled observation freely
// [RL9] full agent asserts stall line
// [RL10] no new transaction while stall seen
// [RL11] stall line is wired-OR of agents
// [RL12] stall driven and sampled on designated edges
// [RL13] priority request halts new unlocked requests
`timescale 1ns/1ps
module sbis_core
  import sbis_pkg::*;
(
  input wire logic I_CLK, // true leg of the differential bus clock
  input wire logic I_RESETN, // synchronous reset, active low
  input wire logic i_observe_strap, // power-on observation enable strap
  input wire logic i_driver_enable, // reinitialize driver enable from configuration
  input wire logic i_fatal_error, // bus condition that breaks future operation
  input wire logic i_bus_reinitialize_n_in, // sensed level of reinitialize pin
  input wire logic i_block_next_request_stall_n_in, // sensed level of stall pin
  input wire logic i_priority_agent_request_n, // priority agent holds the bus
  input wire logic i_locked_op, // ongoing locked operation
  input wire logic i_want_bus, // core wants the request bus
  input wire logic i_new_txn, // core asks to issue a transaction
  input wire logic i_txn_done, // oldest queue entry completed
  input wire logic i_queue_full, // cannot accept more transactions
  output logic o_bus_reinitialize_n_out, // reinitialize pin drive level
  output logic o_bus_reinitialize_n_oe, // reinitialize pin enable
  output logic o_block_next_request_stall_n_out, // stall pin drive level
  output logic o_block_next_request_stall_n_oe, // stall pin enable
  output logic o_issue, // transaction issued this cycle
  output logic o_req_own, // request bus owned
  output logic o_data_own, // data bus owned
  output logic o_pending, // in-order queue not empty
  output logic o_observe_en // captured observation enable
);
  logic strap_done_q; // strap already captured after reset
  logic observe_q; // observation enable latched
  logic reinit_drv_q; // driving reinitialize
  logic stall_drv_q; // driving stall
  logic stall_seen_q; // stall sampled on designated edge
  logic edge_en; // designated stall edge
  sbis_arb_e req_arb_q, req_arb_d; // request arbiter state
  sbis_arb_e data_arb_q, data_arb_d; // data arbiter state
  logic [3:0] qcount_q, qcount_d; // in-order queue occupancy
  logic reinit_seen; // observed reinitialize
  logic may_issue; // issue allowed
  logic issue_w; // issue now
  logic retire_w; // completion now
  // designated edges for the stall line
  sbis_sync_edge u_edge (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .o_edge_en(edge_en)
  );
  // reinitialize seen only when observation enabled
  assign reinit_seen = observe_q && !i_bus_reinitialize_n_in; // RL5
  // issue gate: owner, no stall, no unlocked priority request
  assign may_issue = (req_arb_q == SBIS_ARB_OWN) && !stall_seen_q // RL10
    && (i_priority_agent_request_n || i_locked_op) && !reinit_seen; // RL13
  assign issue_w = may_issue && i_new_txn && (qcount_q < 4'(SBIS_QUEUE_DEPTH));
  assign retire_w = i_txn_done && (qcount_q != SBIS_QCOUNT_RST);
  // queue count survives reinitialize, only issue and retire move it
  assign qcount_d = qcount_q + {3'h0, issue_w} - {3'h0, retire_w}; // RL6
  // request arbiter next state
  always_comb
  begin
    req_arb_d = req_arb_q;
    case (req_arb_q)
      SBIS_ARB_IDLE:
        if (i_want_bus || qcount_q != SBIS_QCOUNT_RST)
          req_arb_d = SBIS_ARB_REQ; // RL7
      SBIS_ARB_REQ:
        if (i_priority_agent_request_n)
          req_arb_d = SBIS_ARB_OWN;
      SBIS_ARB_OWN:
        if (!i_want_bus && qcount_q == SBIS_QCOUNT_RST)
          req_arb_d = SBIS_ARB_IDLE;
      default:
        req_arb_d = SBIS_ARB_IDLE;
    endcase
    if (reinit_seen)
      req_arb_d = SBIS_ARB_IDLE; // RL5
  end
  // data arbiter next state follows pending entries
  always_comb
  begin
    data_arb_d = data_arb_q;
    case (data_arb_q)
      SBIS_ARB_IDLE:
        if (qcount_q != SBIS_QCOUNT_RST)
          data_arb_d = SBIS_ARB_REQ; // RL7
      SBIS_ARB_REQ:
        data_arb_d = SBIS_ARB_OWN;
      SBIS_ARB_OWN:
        if (qcount_q == SBIS_QCOUNT_RST)
          data_arb_d = SBIS_ARB_IDLE;
      default:
        data_arb_d = SBIS_ARB_IDLE;
    endcase
    if (reinit_seen)
      data_arb_d = SBIS_ARB_IDLE; // RL5
  end
  // strap capture at first clock after reset release
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      strap_done_q <= 1'b0;
      observe_q <= SBIS_OBSERVE_RST;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      observe_q <= i_observe_strap; // RL4
    end
  end
  // state registers, all on the rising clock edge
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      req_arb_q <= SBIS_ARB_IDLE;
      data_arb_q <= SBIS_ARB_IDLE;
      qcount_q <= SBIS_QCOUNT_RST;
    end
    else
    begin
      req_arb_q <= req_arb_d; // RL1 RL2
      data_arb_q <= data_arb_d;
      qcount_q <= qcount_d;
    end
  end
  // reinitialize driver: assert on fatal error once enabled
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
      reinit_drv_q <= 1'b0;
    else
      reinit_drv_q <= i_driver_enable && i_fatal_error; // RL3
  end
  // stall drive and sample only on designated edges
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      stall_drv_q <= 1'b0;
      stall_seen_q <= 1'b0;
    end
    else if (edge_en)
    begin
      stall_drv_q <= i_queue_full; // RL9 RL12
      stall_seen_q <= !i_block_next_request_stall_n_in; // RL11
    end
  end
  // registered outputs; pins are open drain, low only when enabled
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      o_bus_reinitialize_n_out <= 1'b1;
      o_bus_reinitialize_n_oe <= 1'b0;
      o_block_next_request_stall_n_out <= 1'b1;
      o_block_next_request_stall_n_oe <= 1'b0;
      o_issue <= 1'b0;
      o_req_own <= 1'b0;
      o_data_own <= 1'b0;
      o_pending <= 1'b0;
      o_observe_en <= 1'b0;
    end
    else
    begin
      o_bus_reinitialize_n_out <= !reinit_drv_q;
      o_bus_reinitialize_n_oe <= reinit_drv_q;
      o_block_next_request_stall_n_out <= !stall_drv_q;
      o_block_next_request_stall_n_oe <= stall_drv_q; // RL11
      o_issue <= issue_w;
      o_req_own <= (req_arb_d == SBIS_ARB_OWN);
      o_data_own <= (data_arb_d == SBIS_ARB_OWN);
      o_pending <= (qcount_d != SBIS_QCOUNT_RST);
      o_observe_en <= observe_q;
    end
  end
  // checks
  a_reinit_drive: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL3
    i_driver_enable && i_fatal_error |=> ##1 o_bus_reinitialize_n_oe && !o_bus_reinitialize_n_out)
    else $error("reinitialize not driven after fatal error");
  a_no_drive_off: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL3
    !i_driver_enable |=> ##1 !o_bus_reinitialize_n_oe)
    else $error("reinitialize driven while disabled");
  a_strap_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL4
    strap_done_q && $past(strap_done_q) |-> $stable(observe_q))
    else $error("observation enable changed after capture");
  a_arb_reset: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL5
    reinit_seen |=> req_arb_q == SBIS_ARB_IDLE && data_arb_q == SBIS_ARB_IDLE)
    else $error("arbiters not reset on reinitialize");
  a_ignore_reinit: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL4
    !observe_q && req_arb_q == SBIS_ARB_OWN && i_want_bus |=> req_arb_q == SBIS_ARB_OWN)
    else $error("reinitialize acted on while not observed");
  a_queue_kept: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL6
    reinit_seen && !i_txn_done |=> qcount_q == $past(qcount_q))
    else $error("queue lost on reinitialize");
  // a reinitialize still seen holds the arbiter idle, so only a quiet bus must re-arbitrate
  a_rearbitrate: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL7
    req_arb_q == SBIS_ARB_IDLE && qcount_q != SBIS_QCOUNT_RST && !reinit_seen
    |=> req_arb_q == SBIS_ARB_REQ)
    else $error("pending entries did not re-arbitrate");
  a_stall_drive: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL9
    edge_en && i_queue_full |=> ##1 o_block_next_request_stall_n_oe)
    else $error("stall not driven when full");
  a_stall_block: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL10
    stall_seen_q |=> !o_issue)
    else $error("issued during stall");
  a_stall_edges: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL12
    !edge_en |=> $stable(stall_drv_q) && $stable(stall_seen_q))
    else $error("stall changed off designated edge");
  a_priority_halt: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RL13
    !i_priority_agent_request_n && !i_locked_op |=> !o_issue)
    else $error("issued under priority request");
endmodule

// [sbis_pkg.sv]
// package with constants shared by the bus init and stall block
package sbis_pkg;
  localparam logic SBIS_OBSERVE_RST = 1'b0; // observation enable value before strap capture
  localparam logic [1:0] SBIS_STALL_PHASE_RST = 2'h0; // stall edge phase counter after reset
  localparam logic [1:0] SBIS_STALL_PHASE_LAST = 2'h1; // stall line is sampled every second edge
  localparam int SBIS_QUEUE_DEPTH = 8; // in-order queue entries tracked
  localparam logic [3:0] SBIS_QCOUNT_RST = 4'h0; // queue occupancy after reset
  // arbitration states of the data and request bus arbiters
  typedef enum logic [1:0] {SBIS_ARB_IDLE, SBIS_ARB_REQ, SBIS_ARB_OWN} sbis_arb_e;
endpackage

// [sbis_sync_edge.sv]
// stall edge phase divider: one-cycle enable on designated bus clock edges
`timescale 1ns/1ps
module sbis_sync_edge
  import sbis_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  output logic o_edge_en
);
  logic [1:0] phase_q; // position within the stall window
  logic [1:0] phase_d; // next position
  // wrap the phase after the last edge of the window
  assign phase_d = (phase_q == SBIS_STALL_PHASE_LAST) ? SBIS_STALL_PHASE_RST : phase_q + 2'h1;
  // phase register and enable pulse
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      phase_q <= SBIS_STALL_PHASE_RST;
      o_edge_en <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      o_edge_en <= (phase_q == SBIS_STALL_PHASE_RST);
    end
  end
endmodule

// [sbis_peer_model.sv]
// peer agents sharing the reinitialize and stall pins
`timescale 1ns/1ps
module sbis_peer_model (
  input wire logic i_clk, // common bus clock
  input wire logic i_stall_req, // peer cannot accept more transactions
  input wire logic i_reinit_req, // peer reports a broken bus
  input wire logic i_dut_stall_out, // device stall drive level
  input wire logic i_dut_stall_oe, // device stall enable
  input wire logic i_dut_reinit_out, // device reinitialize drive level
  input wire logic i_dut_reinit_oe, // device reinitialize enable
  output logic o_stall_n, // wired stall line
  output logic o_reinit_n // wired reinitialize line
);
  logic stall_q = 1'b0; // peer stall drive
  // peer launches its stall drive on the rising edge only
  always @(posedge i_clk)
    stall_q <= i_stall_req;
  // wired-OR of low drivers; the pull-up wins when nobody drives
  assign o_stall_n = !(stall_q | (i_dut_stall_oe & !i_dut_stall_out));
  // priority agent may pull reinitialize at will
  assign o_reinit_n = !(i_reinit_req | (i_dut_reinit_oe & !i_dut_reinit_out));
endmodule

// [testbench.sv]
// self-checking bench for the bus init and stall block
`timescale 1ns/1ps
module testbench;
  import sbis_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, strap = 1'b1, drv_en = 1'b0, fatal = 1'b0;
  logic pri_n = 1'b1, locked = 1'b0, want = 1'b0, new_txn = 1'b0, done = 1'b0;
  logic full = 1'b0, p_stall = 1'b0, p_reinit = 1'b0;
  logic stall_n, reinit_n, ri_out, ri_oe, st_out, st_oe, iss, rown, down, pend, obs;
  int n_mismatch = 0, checks = 0, qcount = 0; // qcount: queue model
  logic [31:0] seed = 32'h50e9; // random source state
  always #12.5 clk = ~clk;
  sbis_core sbis_core_inst (.I_CLK(clk), .I_RESETN(rstn), .i_observe_strap(strap),
    .i_driver_enable(drv_en), .i_fatal_error(fatal), .i_bus_reinitialize_n_in(reinit_n),
    .i_block_next_request_stall_n_in(stall_n), .i_priority_agent_request_n(pri_n),
    .i_locked_op(locked), .i_want_bus(want), .i_new_txn(new_txn), .i_txn_done(done),
    .i_queue_full(full), .o_bus_reinitialize_n_out(ri_out), .o_bus_reinitialize_n_oe(ri_oe),
    .o_block_next_request_stall_n_out(st_out), .o_block_next_request_stall_n_oe(st_oe),
    .o_issue(iss), .o_req_own(rown), .o_data_own(down), .o_pending(pend), .o_observe_en(obs));
  sbis_peer_model sbis_peer_model_inst (.i_clk(clk), .i_stall_req(p_stall),
    .i_reinit_req(p_reinit), .i_dut_stall_out(st_out), .i_dut_stall_oe(st_oe),
    .i_dut_reinit_out(ri_out), .i_dut_reinit_oe(ri_oe), .o_stall_n(stall_n),
    .o_reinit_n(reinit_n));
  // next random value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // compare one flag against the model
  task automatic cmp(input string what, input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // wait n edges and settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reset with a strap value, five edges low
  task automatic reset_dut(input logic s);
    @(posedge clk);
    rstn <= 1'b0;
    strap <= s;
    tick(4);
    qcount = 0; // model queue empties with the design's reset
    cmp("rst_oe", ri_oe | st_oe | iss | rown | down | pend | obs, 1'b0);
    cmp("rst_out", ri_out & st_out, 1'b1);
    @(posedge clk);
    rstn <= 1'b1;
    tick(3);
    cmp("strap", obs, s);
  endtask
  // one transaction request; refused when full or not allowed
  task automatic issue(input logic allow);
    logic exp;
    exp = allow && (qcount < SBIS_QUEUE_DEPTH);
    @(posedge clk);
    new_txn <= 1'b1;
    @(posedge clk);
    new_txn <= 1'b0;
    #1;
    if (exp)
      qcount++;
    cmp("issue", iss, exp);
  endtask
  // one completion pulse, ignored when empty
  task automatic finish_one;
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    if (qcount > 0)
      qcount--;
  endtask
  // wait bounded for request bus ownership
  task automatic wait_own;
    int n;
    n = 0;
    while (rown !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    cmp("own", rown, 1'b1);
  endtask
  // print verdict and end the run
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    #100us;
    n_mismatch++;
    conclude();
  end
  // main sequence
  initial
  begin
    reset_dut(1'b1);
    want <= 1'b1;
    wait_own();
    issue(1'b1);
    $display("test ownership done");
    p_stall <= 1'b1;
    tick(5);
    issue(1'b0);
    p_stall <= 1'b0;
    tick(5);
    issue(1'b1);
    full <= 1'b1;
    tick(5);
    cmp("stall", st_oe & !st_out, 1'b1);
    full <= 1'b0;
    tick(5);
    cmp("stall_off", st_oe & !st_out, 1'b0);
    $display("test stall done");
    pri_n <= 1'b0;
    tick(3);
    issue(1'b0);
    locked <= 1'b1;
    issue(1'b1);
    pri_n <= 1'b1;
    locked <= 1'b0;
    repeat (8) issue(1'b1);
    cmp("pend", pend, qcount != 0);
    cmp("data_own", down, qcount != 0);
    $display("test queue done");
    @(posedge clk);
    p_reinit <= 1'b1;
    @(posedge clk);
    p_reinit <= 1'b0;
    #1;
    cmp("rearb", rown | down, 1'b0);
    cmp("keep", pend, 1'b1);
    wait_own();
    cmp("data_rearb", down, 1'b1);
    seed = lfsr(seed);
    repeat (seed[2:0] + 1) finish_one();
    tick(2);
    cmp("pend_rnd", pend, qcount != 0);
    $display("test observed reinit done");
    fatal <= 1'b1;
    tick(4);
    cmp("no_drv", ri_oe, 1'b0);
    drv_en <= 1'b1;
    tick(4);
    cmp("drv", ri_oe & !ri_out, 1'b1);
    fatal <= 1'b0;
    tick(4);
    cmp("drv_off", ri_oe, 1'b0);
    wait_own();
    $display("test reinit drive done");
    reset_dut(1'b0);
    wait_own();
    p_reinit <= 1'b1;
    tick(3);
    cmp("ignored", rown, 1'b1);
    p_reinit <= 1'b0;
    $display("test strap off done");
    conclude();
  end
endmodule
